// ---- hdl/pmc_pkg.sv ----
package pmc_pkg;
    localparam logic [7:0] PMC_ADDR_POWER_CONTROL = 8'h87;
    localparam logic [7:0] PMC_ADDR_CORE_DIV_CTRL = 8'hF9;
    localparam logic [7:0] PMC_RST_POWER_CONTROL  = 8'h00;
    localparam logic [7:0] PMC_RST_CORE_DIV_CTRL  = 8'h10;
    localparam int PMC_PC_IDLE    = 0;
    localparam int PMC_PC_PDOWN   = 1;
    localparam int PMC_PC_TXFLAG  = 2;
    localparam int PMC_PC_RXFLAG  = 3;
    localparam int PMC_PC_POR     = 4;
    localparam int PMC_PC_LVD_DIS = 5;
    localparam int PMC_PC_SER1_DB = 6;
    localparam int PMC_PC_SER0_DB = 7;
    localparam int PMC_CC_AUTOREC = 3;
    localparam int PMC_CC_DBGCMP  = 4;
    localparam logic [7:0] PMC_CC_WMASK   = 8'h1F;
    localparam logic [2:0] PMC_PS_FULL    = 3'h0;
    localparam int PMC_DIV_W = 11;
    localparam logic [31:0] PMC_ERR_DATA  = 32'h0000_0000;

    typedef struct packed {
        logic gated_core_en;
        logic nonstop_core_en;
        logic prefetch_en;
        logic osc_domain_en;
    } pmc_clk_en_t;

    // log2 of the divide ratio for each prescale code
    function automatic logic [3:0] pmc_div_shift(input logic [2:0] code);
        unique case (code)
            3'h0: pmc_div_shift = 4'h0;
            3'h1: pmc_div_shift = 4'h1;
            3'h2: pmc_div_shift = 4'h2;
            3'h3: pmc_div_shift = 4'h3;
            3'h4: pmc_div_shift = 4'h4;
            3'h5: pmc_div_shift = 4'h5;
            3'h6: pmc_div_shift = 4'hA;
            default: pmc_div_shift = 4'hB;
        endcase
    endfunction
endpackage

// ---- hdl/pmc_prescaler.sv ----
// free-running divider producing one-cycle core enable pulses
module pmc_prescaler #(
    parameter int W = pmc_pkg::PMC_DIV_W
) (
    input  wire logic       ref_clk,   // clock
    input  wire logic       rst_n,     // sync reset
    input  wire logic       run,       // counting allowed
    input  wire logic [3:0] shift,     // log2 ratio
    output logic            tick       // enable pulse
);
    import pmc_pkg::*;
    logic [W-1:0] cnt_reg;
    logic [W-1:0] mask;

    always_comb begin
        mask = W'((W'(1) << shift) - W'(1));
    end

    // a new ratio takes effect at once against the running count, pulses stay whole
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (run) begin
            cnt_reg <= ((cnt_reg & mask) == mask) ? '0 : W'(cnt_reg + W'(1));
        end
    end

    assign tick = run && ((cnt_reg & mask) == mask);
endmodule // pmc_prescaler

// ---- hdl/pmc_power_clock.sv ----
// Summary of operation
// - power-down write is last, then oscillator stops
// - registers keep contents during power-down
// - only external reset exits power-down
// - bit1 power-down request, bit0 idle request
// - bits 7,6 stored as serial baud doublers
// - bit5 set disables low-voltage detector
// - bit4 set by power-on, cleared by software
// - power control at 87H, resets 00H
// - bits 3,2 serial1 receive/transmit clock flags
// - oscillator domain stays undivided when slowed
// - gated core clock off in idle, power-down
// - gated core clock held during prefetch stall
// - gated core clock runs during debug halt
// - nonstop core clock stops only in power-down
// - prefetch clock runs in idle and stall
// - oscillator domain off only in power-down
// - core clock undivided after power-up
// - prescaler write switches rate immediately
// - prescaler codes divide 1..32, 1024, 2048
// - auto recovery forces prescaler 000 on interrupt
// - debug compare enable, 1 after reset
// - divider control at F9H, resets 10H, 7:5 reserved
// - enabled interrupt clears idle bit
//
// Decided for this implementation: the Wishbone interface to the registers.
module pmc_power_clock
    import pmc_pkg::*;
(
    input  wire logic                 ref_clk,          // oscillator reference
    input  wire logic                 rst_n,            // sync reset, low
    input  wire logic                 por_event,        // supervisor power-on reset
    input  wire logic                 irq_pending,      // enabled interrupt request
    input  wire logic                 prefetch_stall,   // prefetch queue not ready
    input  wire logic                 debug_halt,       // debug unit halt
    input  wire logic                 serial1_rx_set,   // hw sets rx clock flag
    input  wire logic                 serial1_tx_set,   // hw sets tx clock flag
    input  wire logic                 wb_cyc_i,         // wishbone cycle
    input  wire logic                 wb_stb_i,         // wishbone strobe
    input  wire logic                 wb_we_i,          // write enable
    input  wire logic [7:0]           wb_adr_i,         // register address
    input  wire logic [3:0]           wb_sel_i,         // byte selects
    input  wire logic [31:0]          wb_dat_i,         // write data
    output logic [31:0]               wb_dat_o,         // read data
    output logic                      wb_ack_o,         // acknowledge
    output pmc_pkg::pmc_clk_en_t      clk_en,           // clock enables
    output logic                      serial0_baud_double, // uart0 double
    output logic                      serial1_baud_double, // uart1 double
    output logic                      low_voltage_detect_disable, // lvd off
    output logic                      debug_compare_enable, // debug compare
    output logic                      power_down_active, // oscillator stopped
    output logic                      idle_active        // idle mode
);
    typedef enum logic [1:0] {PMC_RUN, PMC_IDLE, PMC_PDOWN} pmc_mode_t;

    pmc_mode_t   mode_reg;
    logic [7:0]  power_control_reg;
    logic [7:0]  core_div_ctrl_reg;
    logic        tick;
    logic        wr_pc;
    logic        wr_cc;
    logic        req;
    logic        stopped;
    logic [31:0] rdata;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] reg_adr);
        hit = (adr == reg_adr);
    endfunction

    assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_pc   = req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, PMC_ADDR_POWER_CONTROL);
    assign wr_cc   = req && wb_we_i && wb_sel_i[0] && hit(wb_adr_i, PMC_ADDR_CORE_DIV_CTRL);
    assign stopped = (mode_reg == PMC_PDOWN);

    // core rate divider; oscillator domain never sees it
    pmc_prescaler #(.W(PMC_DIV_W)) u_prescaler (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .run     (!stopped),
        .shift   (pmc_div_shift(core_div_ctrl_reg[2:0])),
        .tick    (tick)
    );

    // power control register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            power_control_reg <= PMC_RST_POWER_CONTROL;
        end else if (!stopped) begin
            if (wr_pc) begin
                power_control_reg <= wb_dat_i[7:0];
            end
            if (irq_pending) begin
                power_control_reg[PMC_PC_IDLE] <= 1'b0;
            end
            if (serial1_rx_set) begin
                power_control_reg[PMC_PC_RXFLAG] <= 1'b1;
            end
            if (serial1_tx_set) begin
                power_control_reg[PMC_PC_TXFLAG] <= 1'b1;
            end
            if (por_event) begin
                power_control_reg[PMC_PC_POR] <= 1'b1;
            end
        end
    end

    // divider control register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            core_div_ctrl_reg <= PMC_RST_CORE_DIV_CTRL;
        end else if (!stopped) begin
            if (wr_cc) begin
                core_div_ctrl_reg <= wb_dat_i[7:0] & PMC_CC_WMASK;
            end
            if (irq_pending && core_div_ctrl_reg[PMC_CC_AUTOREC]) begin
                core_div_ctrl_reg[2:0] <= PMC_PS_FULL;
            end
        end
    end

    // mode sequencer; power-down left only through reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode_reg <= PMC_RUN;
        end else begin
            unique case (mode_reg)
                PMC_RUN: begin
                    if (wr_pc && wb_dat_i[PMC_PC_PDOWN]) begin
                        mode_reg <= PMC_PDOWN;
                    end else if (wr_pc && wb_dat_i[PMC_PC_IDLE] && !irq_pending) begin
                        mode_reg <= PMC_IDLE;
                    end
                end
                PMC_IDLE: begin
                    if (irq_pending) begin
                        mode_reg <= PMC_RUN;
                    end else if (wr_pc && wb_dat_i[PMC_PC_PDOWN]) begin
                        mode_reg <= PMC_PDOWN;
                    end
                end
                PMC_PDOWN: begin
                    mode_reg <= PMC_PDOWN;
                end
                default: mode_reg <= PMC_RUN;
            endcase
        end
    end

    // registered clock enables, one ref_clk wide, never truncated
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            clk_en <= '0;
        end else begin
            clk_en.gated_core_en   <= tick && mode_reg == PMC_RUN
                                      && !prefetch_stall;
            clk_en.nonstop_core_en <= tick && !stopped;
            clk_en.prefetch_en     <= tick && !stopped;
            clk_en.osc_domain_en   <= !stopped;
        end
    end

    // status and field outputs
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            serial0_baud_double        <= 1'b0;
            serial1_baud_double        <= 1'b0;
            low_voltage_detect_disable <= 1'b0;
            debug_compare_enable       <= 1'b1;
            power_down_active          <= 1'b0;
            idle_active                <= 1'b0;
        end else begin
            serial0_baud_double        <= power_control_reg[PMC_PC_SER0_DB];
            serial1_baud_double        <= power_control_reg[PMC_PC_SER1_DB];
            low_voltage_detect_disable <= power_control_reg[PMC_PC_LVD_DIS];
            debug_compare_enable       <= core_div_ctrl_reg[PMC_CC_DBGCMP];
            power_down_active          <= stopped;
            idle_active                <= (mode_reg == PMC_IDLE);
        end
    end

    // read mux; unmapped reads return zero
    always_comb begin
        rdata = PMC_ERR_DATA;
        if (hit(wb_adr_i, PMC_ADDR_POWER_CONTROL)) begin
            rdata = {24'h000000, power_control_reg};
        end else if (hit(wb_adr_i, PMC_ADDR_CORE_DIV_CTRL)) begin
            rdata = {24'h000000, core_div_ctrl_reg};
        end
    end

    // one-wait-state wishbone slave
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rdata : '0;
        end
    end
endmodule // pmc_power_clock

// ---- tb/pmc_power_clock_asserts.sv ----
module pmc_power_clock_asserts
    import pmc_pkg::*;
(
    input wire logic                 ref_clk,        // clock
    input wire logic                 rst_n,          // reset
    input wire logic                 irq_pending,    // interrupt
    input wire logic                 prefetch_stall, // stall
    input wire logic                 wb_cyc_i,       // cycle
    input wire logic                 wb_stb_i,       // strobe
    input wire logic                 wb_we_i,        // write
    input wire logic [7:0]           wb_adr_i,       // address
    input wire logic [31:0]          wb_dat_i,       // write data
    input wire logic                 wb_ack_o,       // ack
    input wire pmc_pkg::pmc_clk_en_t clk_en,         // enables
    input wire logic                 serial0_baud_double,        // uart0
    input wire logic                 serial1_baud_double,        // uart1
    input wire logic                 low_voltage_detect_disable, // lvd
    input wire logic                 power_down_active,          // stopped
    input wire logic                 idle_active                 // idle
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int GAP_MAX = 2100;
    logic [12:0] gap_reg;
    wire         req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire         pc_wr = req && wb_we_i && wb_adr_i == PMC_ADDR_POWER_CONTROL
                         && !power_down_active;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // cycles since the last queue pulse
    always_ff @(posedge ref_clk) begin
        if (!rst_n || clk_en.prefetch_en || power_down_active) gap_reg <= 13'h0;
        else gap_reg <= gap_reg + 13'h1;
    end
    chk_ack_next: assert property (req |=> wb_ack_o) else $error("no ack");
    chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    chk_pc_outputs: assert property (pc_wr |=> ##1
        {serial0_baud_double, serial1_baud_double, low_voltage_detect_disable}
        == $past(wb_dat_i[7:5], 2)) else $error("control outputs wrong");
    chk_idle_dark: assert property (idle_active && $past(idle_active)
        |-> !clk_en.gated_core_en) else $error("core runs in idle");
    chk_stall_dark: assert property (prefetch_stall && $past(prefetch_stall)
        |-> !clk_en.gated_core_en) else $error("core runs in stall");
    chk_pd_dark: assert property (power_down_active && $past(power_down_active)
        |-> clk_en == '0) else $error("clock alive when stopped");
    chk_pd_sticky: assert property (power_down_active |=> power_down_active)
        else $error("power down left");
    chk_osc_alive: assert property ($past(rst_n) |->
        clk_en.osc_domain_en || power_down_active) else $error("osc clock off");
    chk_pfq_gap: assert property (gap_reg < GAP_MAX) else $error("queue clock stuck");
    chk_irq_wakes: assert property (irq_pending |-> ##[1:2] !idle_active)
        else $error("idle not ended");
    cover property (idle_active ##1 !idle_active);
    cover property (power_down_active);
    cover property (prefetch_stall ##1 prefetch_stall);
endmodule // pmc_power_clock_asserts

bind pmc_power_clock pmc_power_clock_asserts u_pmc_power_clock_asserts (
    .ref_clk, .rst_n, .irq_pending, .prefetch_stall, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_i, .wb_ack_o, .clk_en, .serial0_baud_double, .serial1_baud_double,
    .low_voltage_detect_disable, .power_down_active, .idle_active);

// ---- tb/pmc_clock_consumer.sv ----
module pmc_clock_consumer
    import pmc_pkg::*;
(
    input  wire logic                 ref_clk,               // clock
    input  wire pmc_pkg::pmc_clk_en_t clk_en,                // enables
    input  wire logic                 stall_req,             // stall wanted
    input  wire logic                 clr,                   // restart counts
    output logic                      prefetch_stall = 1'b0, // queue empty
    output int                        n_gated = 0,           // core pulses
    output int                        n_nonstop = 0,         // nonstop pulses
    output int                        n_pfq = 0,             // queue pulses
    output int                        n_osc = 0              // osc cycles
);
    timeunit 1ns;
    timeprecision 1ps;
    always @(posedge ref_clk) prefetch_stall <= stall_req;
    always @(posedge ref_clk) begin
        n_gated <= clr ? 0 : n_gated + int'(clk_en.gated_core_en);
        n_nonstop <= clr ? 0 : n_nonstop + int'(clk_en.nonstop_core_en);
        n_pfq <= clr ? 0 : n_pfq + int'(clk_en.prefetch_en);
        n_osc <= clr ? 0 : n_osc + int'(clk_en.osc_domain_en);
    end
endmodule // pmc_clock_consumer

// ---- tb/test_pmc_power_clock.sv ----
module test_pmc_power_clock;
    timeunit 1ns;
    timeprecision 1ps;
    import pmc_pkg::*;
    localparam logic [7:0] PC = PMC_ADDR_POWER_CONTROL;
    localparam logic [7:0] CC = PMC_ADDR_CORE_DIV_CTRL;
    logic ref_clk = 1'b0, rst_n = 1'b0, por_event = 1'b0, irq_pending = 1'b0, debug_halt = 1'b0;
    logic serial1_rx_set = 1'b0, serial1_tx_set = 1'b0, stall_req = 1'b0, clr = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, prefetch_stall;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic serial0_baud_double, serial1_baud_double, low_voltage_detect_disable;
    logic debug_compare_enable, power_down_active, idle_active;
    pmc_clk_en_t clk_en;
    int n_mismatch = 0, n_checks = 0, n_gated, n_nonstop, n_pfq, n_osc;
    int ratio[8] = '{1, 2, 4, 8, 16, 32, 1024, 2048};
    pmc_power_clock u_pmc_power_clock (.ref_clk, .rst_n, .por_event, .irq_pending,
        .prefetch_stall, .debug_halt, .serial1_rx_set, .serial1_tx_set, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .clk_en,
        .serial0_baud_double, .serial1_baud_double, .low_voltage_detect_disable,
        .debug_compare_enable, .power_down_active, .idle_active);
    pmc_clock_consumer u_pmc_clock_consumer (.ref_clk, .clk_en, .stall_req, .clr,
        .prefetch_stall, .n_gated, .n_nonstop, .n_pfq, .n_osc);
    initial forever #4 ref_clk = ~ref_clk;
    task automatic conclude;
        if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [31:0] near(int x, int e);
        return 32'(x >= e - 1 && x <= e + 1);
    endfunction
    task automatic bus(logic w, logic [7:0] a, logic [7:0] d, output logic [7:0] q);
        int t = 0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, 24'h0, d};
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1 && ++t < 50);
        q = wb_dat_o[7:0];
        chk("ack", {wb_ack_o, wb_dat_o[31:8]}, 32'h0100_0000);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        @(posedge ref_clk);
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e, string n);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(n, 32'(q), 32'(e));
    endtask
    // clear counts, then count n settled edges
    task automatic count(int n);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        repeat (n + 1) @(posedge ref_clk);
    endtask
    task automatic irq;
        irq_pending <= 1'b1;
        @(posedge ref_clk);
        irq_pending <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
    initial begin
        repeat (80000) @(posedge ref_clk);
        n_mismatch++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        count(64);
        chk("full speed", near(n_gated, 64), 1);
        chk("dbg enable", 32'(debug_compare_enable), 1);
        rd(PC, 8'h00, "pc reset");
        rd(CC, 8'h10, "cc reset");
        rd(8'h40, 8'h00, "unmapped");
        wr(CC, 8'hFF);
        rd(CC, 8'h1F, "reserved");
        irq();
        rd(CC, 8'h18, "recovery");
        wr(CC, 8'h07);
        irq();
        rd(CC, 8'h07, "no recovery");
        chk("dbg clear", 32'(debug_compare_enable), 0);
        debug_halt <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            wr(CC, 8'(c));
            count(4096);
            chk("core rate", near(n_gated, 4096 / ratio[c]), 1);
            chk("osc rate", 32'(n_osc), 4096);
        end
        wr(CC, 8'h00);
        stall_req <= 1'b1;
        repeat (3) @(posedge ref_clk);
        count(64);
        chk("stall core", 32'(n_gated), 0);
        chk("stall queue", near(n_pfq, 64), 1);
        stall_req <= 1'b0;
        wr(PC, 8'hE0);
        chk("doublers", 32'({serial0_baud_double, serial1_baud_double,
            low_voltage_detect_disable}), 7);
        {serial1_rx_set, serial1_tx_set, por_event} <= 3'b111;
        @(posedge ref_clk);
        {serial1_rx_set, serial1_tx_set, por_event} <= 3'b000;
        rd(PC, 8'hFC, "hw flags");
        wr(PC, 8'h00);
        rd(PC, 8'h00, "sw clear");
        wr(PC, 8'h01);
        count(64);
        chk("idle", {idle_active, n_gated[30:0]}, 32'h8000_0000);
        chk("idle nonstop", near(n_nonstop, 64) & near(n_pfq, 64), 1);
        irq();
        rd(PC, 8'h00, "idle end");
        wr(PC, 8'h02);
        count(8);
        count(64);
        chk("dark", {power_down_active, 31'(n_gated + n_nonstop + n_pfq + n_osc)},
            32'h8000_0000);
        wr(CC, 8'h03);
        irq();
        rd(CC, 8'h00, "held");
        chk("still down", 32'(power_down_active), 1);
        rst_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        chk("reset exit", 32'(power_down_active), 0);
        count(16);
        chk("restart", 32'(n_gated + n_osc), 32);
        rd(PC, 8'h00, "pc after reset");
        conclude();
    end
endmodule // test_pmc_power_clock
